/* File: pkg/reclock_pkg.sv */
package reclock_pkg;
	// Clock and time base
	localparam int CLK_MHZ = 50;
	localparam int DWELL_US = 10;
	localparam int DWELL_CYC = DWELL_US * CLK_MHZ;
	localparam int ACT_NS = 400;
	localparam int ACT_CYC = (ACT_NS * CLK_MHZ) / 1000;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 1;
	// Rate codes
	localparam logic [2:0] RATE_143 = 3'h0;
	localparam logic [2:0] RATE_177 = 3'h1;
	localparam logic [2:0] RATE_270 = 3'h2;
	localparam logic [2:0] RATE_HD = 3'h5;
	localparam logic [1:0] RATE_RSVD_HI = 2'h3;
	// Register map
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_DWELL = 12'h008;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int CTRL_UNLOCK_PASS = 0;
	localparam logic [15:0] DWELL_RESET = 16'(DWELL_CYC);
	localparam int ST_BIT_LOCKED = 0;
	localparam int ST_BIT_ACTIVE = 1;
	localparam int ST_BIT_SD = 2;
	localparam int ST_BIT_AUTO = 3;
	localparam int ST_RATE_LSB = 4;
	localparam int ST_FSM_LSB = 8;
	// Search states
	typedef enum logic [2:0] {
		ST_WAIT = 3'b001,
		ST_TRY = 3'b010,
		ST_LOCK = 3'b100
	} search_t;
endpackage

/* File: rtl/auto_rate_reclock_control.sv */
// How it works
// R01 - Auto mode searches rates and locks itself
// R02 - Auto mode reports locked rate code
// R03 - Lockout skips 177 rate in search
// R04 - Lockout ignored when auto mode off
// R05 - Manual mode: rate pins input, forced lock
// R06 - SD flag high for SD, low HD
// R07 - Cable driver picks slew from SD flag
// R08 - Search waits for input transitions
// R09 - Forced passthrough always bypasses retiming
// R10 - Unlock passthrough bypasses only while unlocked
// R11 - No passthrough: retimed path always
// R12 - Squelch low holds output low
// R13 - Lock lost output high while locked
// R14 - Input choice defaults to input zero
// R15 - Reserved forced codes never lock
// R16 - Static control pins synchronised first
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module rate_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage has no reset; contents are qualified by count
	always_ff @(posedge pclk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule

module auto_rate_reclock_control (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Static control pins
	input wire logic auto_rate_enable,
	input wire logic lockout_177,
	input wire logic forced_passthrough,
	input wire logic output_squelch_n,
	input wire logic [1:0] in_sel,
	input wire logic in_sel_undriven,
	// Rate code pins, two-way
	input wire logic [2:0] rate_in,
	output logic [2:0] rate_out,
	output logic rate_oe,
	// Clock recovery loop
	output logic [2:0] trial_rate,
	input wire logic cdr_lock,
	// Serial data
	input wire logic [3:0] serial_in,
	output logic serial_out,
	// Status pins
	output logic standard_def_flag,
	output logic lock_lost_n
);
	////////////////////////////////////////////////////////////////
	// Two-flop synchronisers; stage one feeds only stage two
	localparam int NS = 12;
	logic [NS-1:0] sync1;
	logic [NS-1:0] sync2;
	wire [NS-1:0] raw_pins = {auto_rate_enable, lockout_177, forced_passthrough,
		output_squelch_n, in_sel, in_sel_undriven, rate_in, 2'h0};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= raw_pins; // [R16]
			sync2 <= sync1; // [R16]
		end
	end

	wire auto_s = sync2[11];
	wire lockout_s = sync2[10];
	wire forced_s = sync2[9];
	wire squelch_n_s = sync2[8];
	wire [1:0] in_sel_s = sync2[7:6];
	wire in_sel_float_s = sync2[5];
	wire [2:0] rate_in_s = sync2[4:2];

	////////////////////////////////////////////////////////////////
	// Input choice and signal detector
	wire [1:0] sel = in_sel_float_s ? 2'h0 : in_sel_s; // [R14]
	wire raw_bit = serial_in[sel];
	logic prev_bit;
	logic [15:0] act_cnt;
	wire activity = act_cnt != 16'h0000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_bit <= 1'b0;
			act_cnt <= 16'h0000;
		end
		else
		begin
			prev_bit <= raw_bit;
			if (raw_bit != prev_bit)
				act_cnt <= 16'(reclock_pkg::ACT_CYC);
			else if (activity)
				act_cnt <= act_cnt - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////
	// APB registers, zero wait states, pslverr on unmapped words
	logic [31:0] ctrl;
	logic [15:0] dwell;
	wire setup = psel && !penable;
	wire hit_ctrl = paddr == reclock_pkg::OFS_CTRL;
	wire hit_status = paddr == reclock_pkg::OFS_STATUS;
	wire hit_dwell = paddr == reclock_pkg::OFS_DWELL;
	wire mapped = hit_ctrl || hit_status || hit_dwell;
	wire wr_en = psel && penable && pready && pwrite;
	wire unlock_pass = ctrl[reclock_pkg::CTRL_UNLOCK_PASS];
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	reclock_pkg::search_t st;
	reclock_pkg::search_t next_st;
	logic [2:0] cur_rate;
	logic [15:0] dwell_cnt;
	wire locked = st == reclock_pkg::ST_LOCK;

	assign status_word = {21'h0, st, 1'b0, cur_rate, auto_s,
		standard_def_flag, activity, locked};
	assign rd_mux = hit_ctrl ? ctrl : hit_status ? status_word :
		hit_dwell ? {16'h0000, dwell} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= reclock_pkg::CTRL_RESET;
			dwell <= reclock_pkg::DWELL_RESET;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !mapped;
			prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
			if (wr_en && hit_ctrl)
				ctrl <= {31'h0, pwdata[reclock_pkg::CTRL_UNLOCK_PASS]};
			if (wr_en && hit_dwell)
				dwell <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Rate search
	wire rsvd_forced = rate_in_s[2:1] == reclock_pkg::RATE_RSVD_HI;
	wire skip_177 = auto_s && lockout_s; // [R04]
	logic [2:0] step_rate;
	logic [2:0] next_rate;
	logic mode_q;
	logic [2:0] forced_q;
	wire mode_change = (mode_q != auto_s) || (!auto_s && forced_q != rate_in_s);

	assign step_rate = (cur_rate >= reclock_pkg::RATE_HD) ? reclock_pkg::RATE_143 :
		cur_rate + 3'h1;
	assign next_rate = (skip_177 && step_rate == reclock_pkg::RATE_177) ?
		reclock_pkg::RATE_270 : step_rate; // [R03]

	always_comb
	begin
		next_st = st;
		case (st)
			reclock_pkg::ST_WAIT:
				if (activity && !(!auto_s && rsvd_forced)) // [R08] [R15]
					next_st = reclock_pkg::ST_TRY;
			reclock_pkg::ST_TRY:
				if (cdr_lock && !(skip_177 && cur_rate == reclock_pkg::RATE_177))
					next_st = reclock_pkg::ST_LOCK; // [R01] [R03]
				else if (!activity)
					next_st = reclock_pkg::ST_WAIT;
			reclock_pkg::ST_LOCK:
				if (!cdr_lock)
					next_st = reclock_pkg::ST_WAIT;
			default:
				next_st = reclock_pkg::ST_WAIT;
		endcase
		if (mode_change || (!auto_s && rsvd_forced) ||
			(skip_177 && cur_rate == reclock_pkg::RATE_177))
			next_st = reclock_pkg::ST_WAIT; // [R15] [R03]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= reclock_pkg::ST_WAIT;
			cur_rate <= reclock_pkg::RATE_143;
			dwell_cnt <= 16'h0000;
			mode_q <= 1'b0;
			forced_q <= 3'h0;
		end
		else
		begin
			st <= next_st;
			mode_q <= auto_s;
			forced_q <= rate_in_s;
			if (!auto_s)
				cur_rate <= rate_in_s; // [R05]
			else if (skip_177 && cur_rate == reclock_pkg::RATE_177)
				cur_rate <= reclock_pkg::RATE_270; // [R03]
			else if (st == reclock_pkg::ST_TRY && next_st == reclock_pkg::ST_TRY &&
				dwell_cnt == 16'h0000)
				cur_rate <= next_rate; // [R01]
			if (st != reclock_pkg::ST_TRY || dwell_cnt == 16'h0000)
				dwell_cnt <= dwell - 16'h0001;
			else
				dwell_cnt <= dwell_cnt - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////
	// Retiming buffer; a squelched output stalls the drain, and capture stops once all 8 entries fill
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_dout;

	rate_fifo #(
		.WIDTH(reclock_pkg::FIFO_WIDTH),
		.DEPTH(reclock_pkg::FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(1'b1),
		.in_ready(fifo_in_ready),
		.in_data(raw_bit),
		.out_valid(fifo_out_valid),
		.out_ready(squelch_n_s),
		.out_data(fifo_dout)
	);

	wire bypass = forced_s || (unlock_pass && !locked); // [R09] [R10]
	wire retimed = fifo_out_valid ? fifo_dout : 1'b0; // [R11]
	wire next_out = !squelch_n_s ? 1'b0 : bypass ? raw_bit : retimed; // [R12]

	////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_out <= 1'b0;
			rate_out <= 3'h0;
			rate_oe <= 1'b0;
			trial_rate <= 3'h0;
			standard_def_flag <= 1'b1;
			lock_lost_n <= 1'b0;
		end
		else
		begin
			serial_out <= next_out;
			rate_oe <= auto_s; // [R05]
			trial_rate <= cur_rate;
			if (locked)
			begin
				rate_out <= cur_rate; // [R02]
				standard_def_flag <= cur_rate != reclock_pkg::RATE_HD; // [R06]
			end
			lock_lost_n <= locked; // [R13]
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_rate_report: assert property (locked |=> rate_out == $past(cur_rate)) // [R02]
		else $error("rate code does not follow locked rate");
	// A lock held when the lockout arrives gets one cycle to drop
	chk_no_177: assert property (skip_177 && $past(skip_177) |-> !(locked && cur_rate == 3'h1)) // [R03]
		else $error("locked to 177 while locked out");
	chk_manual_input: assert property (!auto_s |=> !rate_oe) // [R05]
		else $error("rate pins driven in manual mode");
	chk_sd_flag: assert property (locked |=> standard_def_flag == ($past(cur_rate) != 3'h5)) // [R06]
		else $error("sd flag wrong for locked rate");
	chk_wait_idle: assert property (st == reclock_pkg::ST_WAIT && !activity |=> !locked) // [R08]
		else $error("search left idle without transitions");
	chk_forced_pass: assert property (forced_s && squelch_n_s |=> serial_out == $past(raw_bit)) // [R09]
		else $error("forced passthrough not bypassing");
	chk_unlock_pass: assert property (!forced_s && unlock_pass && !locked && squelch_n_s
		|=> serial_out == $past(raw_bit)) // [R10]
		else $error("unlock passthrough not bypassing");
	chk_retimed_path: assert property (!forced_s && !unlock_pass && squelch_n_s
		|=> serial_out == $past(retimed)) // [R11]
		else $error("retimed path not selected");
	chk_squelch_low: assert property (!squelch_n_s |=> !serial_out) // [R12]
		else $error("squelched output not low");
	chk_lock_flag: assert property (##1 lock_lost_n == $past(locked)) // [R13]
		else $error("lock lost output wrong");
	chk_in_default: assert property (in_sel_float_s |-> sel == 2'h0) // [R14]
		else $error("floating input choice not zero");
	chk_rsvd_nolock: assert property (!auto_s && rsvd_forced |=> !locked) // [R15]
		else $error("locked on reserved forced code");

	cov_auto_lock: cover property (auto_s && st == reclock_pkg::ST_TRY ##1 locked);
	cov_hd_lock: cover property (locked && cur_rate == 3'h5);
	cov_manual_lock: cover property (!auto_s && locked);
	cov_fifo_full: cover property (!fifo_in_ready);
endmodule

`default_nettype wire

/* File: sim/far_side_model.sv */
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
	// Scenario control
	input wire logic pclk,
	input wire logic presetn,
	input wire logic active,
	input wire logic [2:0] target,
	// Device side
	input wire logic [2:0] trial_rate,
	input wire logic standard_def_flag,
	output logic cdr_lock,
	output logic [3:0] serial_in,
	// Cable driver end
	output logic slew_slow
);
	logic [1:0] settle;
	// Cable driver end
	assign slew_slow = standard_def_flag;
	// Loop needs three cycles on the right rate; no data never locks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			settle <= 2'h0;
			serial_in <= 4'h0;
		end
		else
		begin
			settle <= (active && trial_rate == target) ? settle + 2'(settle != 2'h3) : 2'h0;
			serial_in <= active ? serial_in + 4'h7 : serial_in;
		end
	end
	assign cdr_lock = settle == 2'h3;
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct packed {logic a; logic l; logic [2:0] t; logic k; logic sd;} row_t;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic auto = 1'h1, lockout = 1'h0, fpass = 1'h0, squelch_n = 1'h1, undriven = 1'h0;
	logic active = 1'h1, rate_oe, cdr_lock, serial_out, sd_flag, lock_lost_n, slew;
	logic [31:0] hist;
	logic [1:0] in_sel = 2'h0;
	logic [2:0] target = 3'h7, rate_out, trial_rate;
	logic [3:0] serial_in;
	wire logic [2:0] rate_pin;
	int n_fail = 0, check_count = 0, cyc = 0;
	row_t rows [10] = '{'{1'h1, 1'h0, 3'h0, 1'h1, 1'h1}, '{1'h1, 1'h0, 3'h1, 1'h1, 1'h1},
		'{1'h1, 1'h0, 3'h2, 1'h1, 1'h1}, '{1'h1, 1'h0, 3'h3, 1'h1, 1'h1},
		'{1'h1, 1'h1, 3'h4, 1'h1, 1'h1}, '{1'h1, 1'h0, 3'h5, 1'h1, 1'h0},
		'{1'h1, 1'h1, 3'h1, 1'h0, 1'h1}, '{1'h0, 1'h1, 3'h1, 1'h1, 1'h1},
		'{1'h0, 1'h0, 3'h4, 1'h1, 1'h1}, '{1'h0, 1'h0, 3'h6, 1'h0, 1'h1}};
	// Shared rate pins: device drives only while enabled
	assign rate_pin = rate_oe ? rate_out : target;
	always #10 pclk = ~pclk;
	auto_rate_reclock_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .auto_rate_enable(auto), .lockout_177(lockout),
		.forced_passthrough(fpass), .output_squelch_n(squelch_n), .in_sel(in_sel),
		.in_sel_undriven(undriven), .rate_in(rate_pin), .rate_out(rate_out), .rate_oe(rate_oe),
		.trial_rate(trial_rate), .cdr_lock(cdr_lock), .serial_in(serial_in),
		.serial_out(serial_out), .standard_def_flag(sd_flag), .lock_lost_n(lock_lost_n));
	far_side_model partner (.pclk(pclk), .presetn(presetn), .active(active), .target(target),
		.trial_rate(trial_rate), .standard_def_flag(sd_flag), .cdr_lock(cdr_lock),
		.serial_in(serial_in), .slew_slow(slew));
	// Input history, newest nibble lowest: one edge back sits at bits 3:0
	always @(posedge pclk)
		hist <= {hist[27:0], serial_in};
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Output must repeat the chosen input lag edges late: 1 bypassed, 8 through the buffer
	task pass_chk(input int idx, input int lag);
		repeat (5) @(posedge pclk);
		repeat (8)
		begin
			@(posedge pclk);
			chk(serial_out, hist[4*(lag-1)+idx]);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			finish_test;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		chk(lock_lost_n, 1'h0);
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h1);
		apb(1'h0, 12'h008, 32'h0);
		chk(rd, 32'h1f4);
		apb(1'h0, 12'h00c, 32'h0);
		chk(err, 1'h1);
		chk(rd, 32'h0);
		// Short dwell keeps each search pass near fifty cycles
		apb(1'h1, 12'h008, 32'h8);
		$display("register test done");
		for (int i = 0; i < 10; i++)
		begin
			@(posedge pclk);
			auto <= rows[i].a;
			lockout <= rows[i].l;
			target <= rows[i].t;
			repeat (6) @(posedge pclk);
			for (int j = 0; j < 300 && lock_lost_n !== 1'h1; j++) @(posedge pclk);
			repeat (2) @(posedge pclk);
			chk(lock_lost_n, rows[i].k);
			chk(rate_oe, rows[i].a);
			if (rows[i].k)
			begin
				chk(rate_out, rows[i].t);
				chk(sd_flag, rows[i].sd);
				chk(slew, rows[i].sd);
			end
			$display("rate row %0d done", i);
		end
		@(posedge pclk);
		target <= 3'h7;
		fpass <= 1'h1;
		for (int s = 0; s < 4; s++)
		begin
			in_sel <= 2'(s);
			pass_chk(s, 1);
		end
		undriven <= 1'h1;
		pass_chk(0, 1);
		fpass <= 1'h0;
		pass_chk(0, 1);
		squelch_n <= 1'h0;
		repeat (5) @(posedge pclk);
		repeat (8)
		begin
			@(posedge pclk);
			chk(serial_out, 1'h0);
		end
		// Both passthrough controls off: stale bits drain first, then an 8 edge lag
		apb(1'h1, 12'h000, 32'h0);
		undriven <= 1'h0;
		squelch_n <= 1'h1;
		repeat (12) @(posedge pclk);
		pass_chk(3, 8);
		$display("output path test done");
		// A valid forced code, so only the missing transitions hold the search idle
		target <= 3'h2;
		active <= 1'h0;
		repeat (60) @(posedge pclk);
		apb(1'h0, 12'h004, 32'h0);
		chk(rd[10:8], 3'h1);
		chk(rd[1], 1'h0);
		$display("no data test done");
		finish_test;
	end
endmodule
`default_nettype wire
